//--- rtl/ppmux_pkg.sv
// Package: constants and types for the parallel port pin mux
package ppmux_pkg;

  // Bus function select encodings
  typedef enum logic [1:0] {
    PPMUX_MODE_DATA_MEM = 2'h0,
    PPMUX_MODE_FULL_MEM = 2'h1,
    PPMUX_MODE_HOST     = 2'h2,
    PPMUX_MODE_HOST_MUX = 2'h3
  } ppmux_mode_t;

  // Number of shared terminals, C4 to C10
  localparam int unsigned PPMUX_NUM_PINS = 7;

  // Terminal positions in the pin vectors
  localparam int unsigned PPMUX_PIN_C4  = 0;
  localparam int unsigned PPMUX_PIN_C5  = 1;
  localparam int unsigned PPMUX_PIN_C6  = 2;
  localparam int unsigned PPMUX_PIN_C7  = 3;
  localparam int unsigned PPMUX_PIN_C8  = 4;
  localparam int unsigned PPMUX_PIN_C9  = 5;
  localparam int unsigned PPMUX_PIN_C10 = 6;

  // Host register selections decoded from the two select inputs
  typedef enum logic [1:0] {
    PPMUX_HREG_CTRL    = 2'h0,
    PPMUX_HREG_DATA_AI = 2'h1,
    PPMUX_HREG_ADDR    = 2'h2,
    PPMUX_HREG_DATA    = 2'h3
  } ppmux_hreg_t;

  // Values after reset
  localparam logic [15:0] PPMUX_HADDR_RST   = 16'h0000;
  localparam logic [6:0]  PPMUX_PINS_RST    = 7'h7F;
  localparam logic [6:0]  PPMUX_OE_RST      = 7'h00;
  localparam logic [1:0]  PPMUX_BYTE_ID_RST = 2'h3;

endpackage : ppmux_pkg

//--- rtl/ppmux_sync2.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module ppmux_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock
  input  wire logic             clk,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ppmux_sync_t;

  ppmux_sync_t s_q;
  ppmux_sync_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  // No reset: the stages keep sampling while the block is held in reset
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.sync;

endmodule // ppmux_sync2

`default_nettype wire

//--- rtl/ppmux_top.sv
// Pin mux for parallel port terminals C4 to C10
// How it works
// - C4 is memory space 0 select in modes 00/01 and general-purpose bit nine in 10/11.
// - C5 is memory space 1 select in modes 00/01 and general-purpose bit ten in 10/11.
// - C6 is memory space 2 select in modes 00/01 and host register select 0 in 10/11.
// - In mode 11 the host drives both register selects together and the device decodes the pair.
// - C7 is memory space 3 select in modes 00/01 and general-purpose bit eleven in mode 10.
// - C7 is host register select 1 only in mode 11.
// - C8 is memory byte enable 0 in modes 00/01, otherwise host byte id 0 input.
// - C9 is memory byte enable 1 in modes 00/01, otherwise host byte id 1 input.
// - In host modes the byte id 0 input (C8) alone tells first from second byte for placement.
// - C10 is the SDRAM row strobe in modes 00/01 and general-purpose bit twelve in mode 10.
// - In mode 11 C10 is the host address strobe whose assertion latches the address.
// - At reset the boot strap selects memory outputs (1) or host/general inputs (0).
// - All memory selects, byte enables and row strobe are active-low and can float.
// - Mode 01 is full memory mode with the address bus driven by the memory controller.
// - Mode 11 is multiplexed host mode with the upper address pins under general-purpose control.
// - Mode 00 is data-only memory mode with the upper address pins general-purpose.
`timescale 1ns/1ps
`default_nettype none

module ppmux_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Boot strap and bus function select
  input  wire logic        boot_strap_pin,
  input  wire logic [1:0]  bus_func_sel,
  input  wire logic        bus_func_sel_we,
  // Memory controller side
  input  wire logic        mem_space0_select_n,
  input  wire logic        mem_space1_select_n,
  input  wire logic        mem_space2_select_n,
  input  wire logic        mem_space3_select_n,
  input  wire logic        mem_byte_en0_n,
  input  wire logic        mem_byte_en1_n,
  input  wire logic        sdram_row_strobe_n,
  input  wire logic        ext_mem_ctrl_drive_en,
  // General-purpose register bits nine to twelve
  input  wire logic [3:0]  gp_dir,
  input  wire logic [3:0]  gp_out,
  output logic      [3:0]  gp_in,
  // Host port side
  input  wire logic [15:0] host_data_in,
  output logic      [1:0]  host_reg_sel,
  output logic             host_reg_sel_valid,
  output logic      [1:0]  host_byte_id_n,
  output logic             host_byte_first,
  output logic      [15:0] host_address_reg,
  output logic             host_address_strobe,
  // Mode status
  output logic      [1:0]  bus_mode,
  output logic             upper_addr_gp,
  output logic             addr_bus_by_mem,
  // Terminals C4 to C10
  input  wire logic [6:0]  pin_in,
  output logic      [6:0]  pin_out,
  output logic      [6:0]  pin_oe
);

  typedef struct packed {
    ppmux_pkg::ppmux_mode_t mode;
    logic                   strap_taken;
    logic                   has_prev;
    logic [6:0]             pout;
    logic [6:0]             poe;
    logic [3:0]             gp_in;
    logic [1:0]             hsel;
    logic                   hsel_valid;
    logic [1:0]             hbid;
    logic                   hfirst;
    logic [15:0]            haddr;
    logic                   hstrobe;
    logic                   upper_gp;
    logic                   addr_mem;
  } ppmux_state_t;

  ppmux_state_t s_q;
  ppmux_state_t s_d;
  logic [6:0]   pin_sync;
  logic [15:0]  data_sync;
  logic         strap_sync;

  localparam int unsigned PPMUX_W = 24;

  // Synchroniser runs through reset so the strap is settled at release
  ppmux_sync2 #(.WIDTH(PPMUX_W)) u_sync (
    .clk      (clk),
    .async_in ({boot_strap_pin, host_data_in, pin_in}),
    .sync_out ({strap_sync, data_sync, pin_sync})
  );

  always_comb begin
    logic mem_mode;
    logic host_mode;
    logic mux_mode;
    mem_mode  = 1'b0;
    host_mode = 1'b0;
    mux_mode  = 1'b0;
    s_d       = s_q;
    // Boot strap picks the first mode once after reset
    // strap sets mode
    if (!s_q.strap_taken) begin
      s_d.strap_taken = 1'b1;
      s_d.mode = strap_sync ? ppmux_pkg::PPMUX_MODE_FULL_MEM : ppmux_pkg::PPMUX_MODE_HOST;
    end else if (bus_func_sel_we) begin
      s_d.mode = ppmux_pkg::ppmux_mode_t'(bus_func_sel);
    end
    unique case (s_d.mode)
      ppmux_pkg::PPMUX_MODE_DATA_MEM: begin
        mem_mode     = 1'b1;
        mux_mode     = 1'b0;
        s_d.addr_mem = 1'b0;
        s_d.upper_gp = 1'b1;
      end
      ppmux_pkg::PPMUX_MODE_FULL_MEM: begin
        mem_mode     = 1'b1;
        mux_mode     = 1'b0;
        s_d.addr_mem = 1'b1;
        s_d.upper_gp = 1'b0;
      end
      ppmux_pkg::PPMUX_MODE_HOST: begin
        // Plain host mode, address pins stay with the host
        mem_mode     = 1'b0;
        mux_mode     = 1'b0;
        s_d.addr_mem = 1'b0;
        s_d.upper_gp = 1'b0;
      end
      ppmux_pkg::PPMUX_MODE_HOST_MUX: begin
        mem_mode     = 1'b0;
        mux_mode     = 1'b1;
        s_d.addr_mem = 1'b0;
        s_d.upper_gp = 1'b1;
      end
    endcase
    host_mode = !mem_mode;
    // Idle level, pins released unless a function drives them
    s_d.pout = ppmux_pkg::PPMUX_PINS_RST;
    s_d.poe  = ppmux_pkg::PPMUX_OE_RST;
    if (mem_mode) begin
      s_d.pout[ppmux_pkg::PPMUX_PIN_C4] = mem_space0_select_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C5] = mem_space1_select_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C6] = mem_space2_select_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C7] = mem_space3_select_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C8] = mem_byte_en0_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C9] = mem_byte_en1_n;
      s_d.pout[ppmux_pkg::PPMUX_PIN_C10] = sdram_row_strobe_n;
      s_d.poe = {7{ext_mem_ctrl_drive_en}};
    end else begin
      s_d.pout[ppmux_pkg::PPMUX_PIN_C4] = gp_out[0];
      s_d.poe[ppmux_pkg::PPMUX_PIN_C4]  = gp_dir[0];
      s_d.pout[ppmux_pkg::PPMUX_PIN_C5] = gp_out[1];
      s_d.poe[ppmux_pkg::PPMUX_PIN_C5]  = gp_dir[1];
      if (!mux_mode) begin
        // bits eleven and twelve only in mode 10
        s_d.pout[ppmux_pkg::PPMUX_PIN_C7]  = gp_out[2];
        s_d.poe[ppmux_pkg::PPMUX_PIN_C7]   = gp_dir[2];
        s_d.pout[ppmux_pkg::PPMUX_PIN_C10] = gp_out[3];
        s_d.poe[ppmux_pkg::PPMUX_PIN_C10]  = gp_dir[3];
      end
    end
    // General-purpose input levels
    s_d.gp_in = {pin_sync[ppmux_pkg::PPMUX_PIN_C10],
                 pin_sync[ppmux_pkg::PPMUX_PIN_C7],
                 pin_sync[ppmux_pkg::PPMUX_PIN_C5],
                 pin_sync[ppmux_pkg::PPMUX_PIN_C4]};
    s_d.hsel       = {mux_mode ? pin_sync[ppmux_pkg::PPMUX_PIN_C7] : 1'b0,
                      pin_sync[ppmux_pkg::PPMUX_PIN_C6]};
    s_d.hsel_valid = host_mode;
    s_d.hbid   = host_mode ? {pin_sync[ppmux_pkg::PPMUX_PIN_C9], pin_sync[ppmux_pkg::PPMUX_PIN_C8]}
                           : ppmux_pkg::PPMUX_BYTE_ID_RST;
    s_d.hfirst = host_mode && !pin_sync[ppmux_pkg::PPMUX_PIN_C8];
    // address strobe latches address on falling edge
    // Follows the pin in every mode, so entering mode 11 with the pin low is no edge
    s_d.has_prev = pin_sync[ppmux_pkg::PPMUX_PIN_C10];
    s_d.hstrobe  = mux_mode && s_q.has_prev && !pin_sync[ppmux_pkg::PPMUX_PIN_C10];
    if (s_d.hstrobe) begin
      s_d.haddr = data_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.mode     <= ppmux_pkg::PPMUX_MODE_HOST;
      s_q.has_prev <= 1'b1;
      s_q.pout     <= ppmux_pkg::PPMUX_PINS_RST;
      s_q.poe      <= ppmux_pkg::PPMUX_OE_RST;
      s_q.hbid     <= ppmux_pkg::PPMUX_BYTE_ID_RST;
      s_q.haddr    <= ppmux_pkg::PPMUX_HADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out             = s_q.pout;
  assign pin_oe              = s_q.poe;
  assign gp_in               = s_q.gp_in;
  assign host_reg_sel        = s_q.hsel;
  assign host_reg_sel_valid  = s_q.hsel_valid;
  assign host_byte_id_n      = s_q.hbid;
  assign host_byte_first     = s_q.hfirst;
  assign host_address_reg    = s_q.haddr;
  assign host_address_strobe = s_q.hstrobe;
  assign bus_mode            = s_q.mode;
  assign upper_addr_gp       = s_q.upper_gp;
  assign addr_bus_by_mem     = s_q.addr_mem;

endmodule // ppmux_top

`default_nettype wire

//--- tb/ppmux_props.sv
// Assertions on the parallel port pin mux top ports
`timescale 1ns/1ps
`default_nettype none
module ppmux_props (
  // Clock, reset and controls
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        boot_strap_pin,
  input wire logic        ext_mem_ctrl_drive_en,
  input wire logic [3:0]  gp_dir,
  // Memory controller side
  input wire logic        mem_space0_select_n,
  input wire logic        mem_space1_select_n,
  input wire logic        mem_space2_select_n,
  input wire logic        mem_space3_select_n,
  input wire logic        mem_byte_en0_n,
  input wire logic        mem_byte_en1_n,
  input wire logic        sdram_row_strobe_n,
  // Status, host side and terminals
  input wire logic [1:0]  bus_mode,
  input wire logic        upper_addr_gp,
  input wire logic        addr_bus_by_mem,
  input wire logic [1:0]  host_reg_sel,
  input wire logic        host_reg_sel_valid,
  input wire logic [1:0]  host_byte_id_n,
  input wire logic [15:0] host_address_reg,
  input wire logic        host_address_strobe,
  input wire logic [6:0]  pin_out,
  input wire logic [6:0]  pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_mem;
    !$past(sys_rst) && $stable(bus_mode) && !bus_mode[1] && $past(ext_mem_ctrl_drive_en)
      |-> pin_oe == 7'h7F && pin_out == $past({sdram_row_strobe_n, mem_byte_en1_n,
      mem_byte_en0_n, mem_space3_select_n, mem_space2_select_n, mem_space1_select_n,
      mem_space0_select_n});
  endproperty
  a_mem: assert property (p_mem) else $error("memory pins wrong");
  property p_float;
    !$past(sys_rst) && $stable(bus_mode) && !bus_mode[1] && !$past(ext_mem_ctrl_drive_en)
      |-> pin_oe == 7'h00;
  endproperty
  a_float: assert property (p_float) else $error("pins not floated");
  property p_gp;
    !$past(sys_rst) && $stable(bus_mode) && bus_mode == 2'h2
      |-> {pin_oe[6], pin_oe[3], pin_oe[1:0]} == $past(gp_dir) && pin_oe[5:4] == 2'h0
      && !pin_oe[2];
  endproperty
  a_gp: assert property (p_gp) else $error("host mode directions wrong");
  property p_mux;
    !$past(sys_rst) && $stable(bus_mode) && bus_mode == 2'h3
      |-> pin_oe[1:0] == $past(gp_dir[1:0]) && pin_oe[6:2] == 5'h00;
  endproperty
  a_mux: assert property (p_mux) else $error("mux host directions wrong");
  property p_sel;
    !$past(sys_rst) && $stable(bus_mode) |-> host_reg_sel_valid == bus_mode[1]
      && (bus_mode != 2'h2 || !host_reg_sel[1]);
  endproperty
  a_sel: assert property (p_sel) else $error("register select wrong");
  property p_byte;
    !$past(sys_rst) && $stable(bus_mode) && !bus_mode[1] |-> host_byte_id_n == 2'h3;
  endproperty
  a_byte: assert property (p_byte) else $error("byte id active");
  property p_stat;
    addr_bus_by_mem == (bus_mode == 2'h1) && upper_addr_gp == (bus_mode[0] == bus_mode[1]);
  endproperty
  a_stat: assert property (p_stat) else $error("mode status wrong");
  property p_strb;
    host_address_strobe |-> bus_mode == 2'h3 ##1 !host_address_strobe;
  endproperty
  a_strb: assert property (p_strb) else $error("address strobe wrong");
  property p_hold;
    !host_address_strobe |-> $stable(host_address_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("address changed");
  property p_strap;
    $fell(sys_rst) |=> bus_mode == (boot_strap_pin ? 2'h1 : 2'h2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap mode wrong");
  c_strb: cover property (host_address_strobe);
  c_float: cover property (!bus_mode[1] && pin_oe == 7'h00);
  c_mux: cover property (bus_mode == 2'h3 && host_reg_sel == 2'h2);
endmodule // ppmux_props
bind ppmux_top ppmux_props u_props (.clk, .sys_rst, .boot_strap_pin, .ext_mem_ctrl_drive_en,
  .gp_dir, .mem_space0_select_n, .mem_space1_select_n, .mem_space2_select_n,
  .mem_space3_select_n, .mem_byte_en0_n, .mem_byte_en1_n, .sdram_row_strobe_n, .bus_mode,
  .upper_addr_gp, .addr_bus_by_mem, .host_reg_sel, .host_reg_sel_valid, .host_byte_id_n,
  .host_address_reg, .host_address_strobe, .pin_out, .pin_oe);
`default_nettype wire

//--- tb/ppmux_ext_model.sv
// Far-side host model resolving the shared terminals
`timescale 1ns/1ps
`default_nettype none
module ppmux_ext_model (
  // Device side
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  // Host drive levels
  input  wire logic [6:0] host_drv,
  // Resolved terminal levels
  output logic      [6:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : host_drv[i];
    end
  end
endmodule // ppmux_ext_model
`default_nettype wire

//--- tb/ppmux_test.sv
// Self-checking testbench for the parallel port pin mux
`timescale 1ns/1ps
`default_nettype none
module ppmux_test;
  logic        clk = 1'b0, sys_rst = 1'b1, boot_strap_pin = 1'b1, bus_func_sel_we = 1'b0;
  logic        ext_mem_ctrl_drive_en = 1'b1, host_reg_sel_valid, host_byte_first;
  logic        host_address_strobe, upper_addr_gp, addr_bus_by_mem;
  logic [1:0]  bus_func_sel = 2'h0, host_reg_sel, host_byte_id_n, bus_mode;
  logic [3:0]  gp_dir = 4'h0, gp_out = 4'h0, gp_in;
  logic [6:0]  mem = 7'h7F, host_drv = 7'h7F, pin_in, pin_out, pin_oe;
  logic [15:0] host_data_in = 16'h0000, host_address_reg;
  int          failures = 0, n_checks = 0;
  always #25 clk = ~clk;
  ppmux_top dut (.clk, .sys_rst, .boot_strap_pin, .bus_func_sel, .bus_func_sel_we,
    .mem_space0_select_n(mem[0]), .mem_space1_select_n(mem[1]),
    .mem_space2_select_n(mem[2]), .mem_space3_select_n(mem[3]), .mem_byte_en0_n(mem[4]),
    .mem_byte_en1_n(mem[5]), .sdram_row_strobe_n(mem[6]), .ext_mem_ctrl_drive_en, .gp_dir,
    .gp_out, .gp_in, .host_data_in, .host_reg_sel, .host_reg_sel_valid, .host_byte_id_n,
    .host_byte_first, .host_address_reg, .host_address_strobe, .bus_mode, .upper_addr_gp,
    .addr_bus_by_mem, .pin_in, .pin_out, .pin_oe);
  ppmux_ext_model u_ext (.pin_out, .pin_oe, .host_drv, .pin_in);
  task automatic results();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    boot_strap_pin = s;
    sys_rst = 1'b1;
    step(3);
    sys_rst = 1'b0;
    step(3);
  endtask
  task automatic set_mode(input logic [1:0] m);
    bus_func_sel = m;
    bus_func_sel_we = 1'b1;
    step(1);
    bus_func_sel_we = 1'b0;
    step(2);
  endtask
  task automatic t_mem();
    do_reset(1'b1);
    chk(bus_mode === 2'h1 && pin_oe === 7'h7F && addr_bus_by_mem === 1'b1, "strap 1");
    for (int i = 0; i < 7; i++) begin
      mem = ~(7'h01 << i);
      step(2);
      chk(pin_out === mem && pin_oe === 7'h7F, "memory pin");
    end
    ext_mem_ctrl_drive_en = 1'b0;
    step(2);
    chk(pin_oe === 7'h00, "float");
    ext_mem_ctrl_drive_en = 1'b1;
    set_mode(2'h0);
    chk(upper_addr_gp === 1'b1 && addr_bus_by_mem === 1'b0, "data-only mode");
  endtask
  task automatic t_gp();
    do_reset(1'b0);
    chk(bus_mode === 2'h2 && pin_oe === 7'h00, "strap 0");
    gp_dir = 4'hF;
    gp_out = 4'hA;
    step(2);
    chk(pin_oe === 7'h4B && {pin_out[6], pin_out[3], pin_out[1:0]} === 4'hA, "gp out");
    gp_dir = 4'h0;
    host_drv = 7'h4C;
    step(5);
    chk(gp_in === 4'hC && host_reg_sel === 2'h1 && host_reg_sel_valid === 1'b1, "gp in");
    chk(host_byte_id_n === 2'h0, "byte id");
  endtask
  task automatic t_mux();
    int i;
    set_mode(2'h3);
    gp_dir = 4'hF;
    host_drv = 7'h58;
    host_data_in = 16'hA5C3;
    step(5);
    chk(host_reg_sel === 2'h2 && host_byte_id_n === 2'h1 && host_byte_first === 1'b0, "sel");
    chk(pin_oe === 7'h03 && upper_addr_gp === 1'b1, "mux dirs");
    host_drv[6] = 1'b0;
    for (i = 0; i < 8 && host_address_strobe !== 1'b1; i++) step(1);
    chk(i < 8, "address strobe timeout");
    chk(host_address_reg === 16'hA5C3, "latched address");
    step(1);
    chk(host_address_strobe === 1'b0, "strobe width");
  endtask
  initial begin
    t_mem();
    t_gp();
    t_mux();
    results();
  end
endmodule // ppmux_test
`default_nettype wire
